/* rtl/eqo_regs.svh */
`ifndef EQO_REGS_SVH
`define EQO_REGS_SVH
// register byte offsets
`define EQO_ERR_SUM_OFS 8'h00
`define EQO_ERR_MSG_OFS 8'h04
`define EQO_AUX_ERR_OFS 8'h08
`define EQO_ERROR_ENABLE_MASK_OFS 8'h0C
`define EQO_STATUS_OFS 8'h10
`define EQO_RQS_OFS 8'h14
`define EQO_EXTERNAL_EVENT_OUTPUT_OFS 8'h18
`define EQO_DEFAULTS_OFS 8'h1C
// widths and field positions
`define EQO_MAIN_W 15
`define EQO_AUX_W 16
`define EQO_STAT_W 8
`define EQO_STAT_ERR_BIT 5
`define EQO_STAT_SRQ_BIT 6
`define EQO_EXT_POL_BIT 8
// reset and default values
`define EQO_ERROR_ENABLE_MASK_RST 15'h7FFF
`define EQO_RQS_RST 8'h00
`define EQO_POL_RST 1'b0
// reply numbers
`define EQO_MAIN_BASE 16'h0064
`define EQO_AUX_BASE 16'h00C8
`define EQO_MSG_MAX_LEN 8'hFF
// timing
`define EQO_CLK_MHZ 20
`define EQO_PULSE_NS 1000
`define EQO_PULSE_CYC ((`EQO_PULSE_NS * `EQO_CLK_MHZ) / 1000)
`endif

/* rtl/eqo_pkg.sv */
package eqo_pkg;
    typedef enum logic [2:0] {
        EQO_EV_OFF = 3'h0,
        EQO_EV_INPUT = 3'h1,
        EQO_EV_ONCE = 3'h2,
        EQO_EV_APERTURE_LEVEL_EVENT = 3'h3,
        EQO_EV_BURST = 3'h4,
        EQO_EV_SRQ = 3'h5,
        EQO_EV_READING = 3'h6
    } eqo_evt_t;
endpackage

/* rtl/eqo_error_event.sv */
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "eqo_regs.svh"
module eqo_error_event (
    input wire logic i_core_clk, // 20 MHz core clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb direction
    input wire logic [7:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic o_pready, // apb ready
    output logic [31:0] o_prdata, // apb read data
    output logic o_pslverr, // apb unmapped address
    input wire logic [`EQO_MAIN_W-1:0] i_main_err_set, // main error pulses
    input wire logic [`EQO_AUX_W-1:0] i_aux_err_set, // auxiliary error pulses
    input wire logic [`EQO_STAT_W-1:0] i_status_evt, // status event pulses
    input wire logic i_input_done, // converter input complete
    input wire logic i_burst_done, // group of readings done
    input wire logic i_reading_done, // single reading done
    input wire logic i_aperture, // converter measuring window
    output logic o_ext_out, // external event output pin
    output logic o_err_ind, // error indicator
    output logic o_srq // service request
);
    import eqo_pkg::*;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    localparam logic [4:0] PULSE_CYC = 5'(`EQO_PULSE_CYC);

    function automatic logic [4:0] lsb_idx(input logic [15:0] v);
        lsb_idx = 5'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                lsb_idx = 5'(i);
            end
        end
    endfunction

    logic [`EQO_MAIN_W-1:0] main_r, main_nxt;
    logic [`EQO_AUX_W-1:0] aux_r, aux_nxt;
    logic [`EQO_MAIN_W-1:0] error_enable_mask_r;
    logic [`EQO_STAT_W-1:0] rqs_r;
    logic err_bit_r, srq_r, ind_r;
    eqo_evt_t sel_r;
    logic pol_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic [4:0] pulse_cnt;
    logic pulse_act, ext_r;

    logic setup, rd_acc, wr_acc;
    logic sum_rd, msg_rd, stat_wr, ext_wr, dflt_wr;
    logic mapped;
    logic [`EQO_MAIN_W-1:0] main_ev;
    logic [`EQO_STAT_W-1:0] stat_ev;
    logic err_ev, srq_ev, fire;
    logic [4:0] aux_idx, main_idx;
    logic [15:0] msg_num;
    eqo_evt_t wsel;

    assign setup = i_psel && !i_penable;
    assign rd_acc = i_psel && i_penable && pready_r && !i_pwrite;
    assign wr_acc = i_psel && i_penable && pready_r && i_pwrite;
    assign sum_rd = rd_acc && i_paddr == `EQO_ERR_SUM_OFS;
    assign msg_rd = rd_acc && i_paddr == `EQO_ERR_MSG_OFS;
    assign stat_wr = wr_acc && i_paddr == `EQO_STATUS_OFS;
    assign ext_wr = wr_acc && i_paddr == `EQO_EXTERNAL_EVENT_OUTPUT_OFS;
    assign dflt_wr = wr_acc && i_paddr == `EQO_DEFAULTS_OFS;
    assign wsel = eqo_evt_t'(i_pwdata[2:0]);

    // every new error latches regardless of the mask
    assign main_ev = i_main_err_set | {14'h0, |i_aux_err_set};
    assign err_ev = |(main_ev & error_enable_mask_r);
    always_comb begin
        stat_ev = i_status_evt;
        stat_ev[`EQO_STAT_ERR_BIT] = i_status_evt[`EQO_STAT_ERR_BIT] | err_ev;
    end
    assign srq_ev = |(stat_ev & rqs_r);

    assign aux_idx = lsb_idx(aux_r);
    assign main_idx = lsb_idx({1'b0, main_r[`EQO_MAIN_W-1:1], 1'b0});

    // auxiliary bits go first while any is pending
    always_comb begin
        if (aux_r != '0) begin
            msg_num = `EQO_AUX_BASE + {11'h0, aux_idx};
        end else if (main_r[`EQO_MAIN_W-1:1] != '0) begin
            msg_num = `EQO_MAIN_BASE + {11'h0, main_idx};
        end else begin
            msg_num = 16'h0;
        end
    end

    // set wins over any clear in the same cycle
    always_comb begin
        aux_nxt = aux_r;
        if (sum_rd) begin
            aux_nxt = '0;
        end else if (msg_rd && aux_r != '0) begin
            aux_nxt[aux_idx[3:0]] = 1'b0;
        end
        aux_nxt = aux_nxt | i_aux_err_set;
    end

    always_comb begin
        main_nxt = main_r;
        if (sum_rd) begin
            main_nxt = '0;
        end else if (msg_rd && aux_r == '0 && main_r[`EQO_MAIN_W-1:1] != '0) begin
            main_nxt[main_idx[3:0]] = 1'b0;
        end
        main_nxt = main_nxt | i_main_err_set;
        main_nxt[0] = |aux_nxt;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            main_r <= '0;
            aux_r <= '0;
            ind_r <= 1'b0;
        end else begin
            main_r <= main_nxt;
            aux_r <= aux_nxt;
            ind_r <= main_nxt != '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_bit_r <= 1'b0;
        end else if (err_ev) begin
            err_bit_r <= 1'b1;
        end else if (sum_rd) begin
            err_bit_r <= 1'b0;
        end else if (msg_rd && main_nxt == '0 && aux_nxt == '0) begin
            err_bit_r <= 1'b0;
        end
    end

    // sticky until software writes a one to clear it
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            srq_r <= 1'b0;
        end else if (srq_ev) begin
            srq_r <= 1'b1;
        end else if (stat_wr && i_pwdata[`EQO_STAT_SRQ_BIT]) begin
            srq_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            error_enable_mask_r <= `EQO_ERROR_ENABLE_MASK_RST;
            rqs_r <= `EQO_RQS_RST;
        end else if (dflt_wr) begin
            error_enable_mask_r <= `EQO_ERROR_ENABLE_MASK_RST;
        end else if (wr_acc && i_paddr == `EQO_ERROR_ENABLE_MASK_OFS) begin
            error_enable_mask_r <= i_pwdata[`EQO_MAIN_W-1:0];
        end else if (wr_acc && i_paddr == `EQO_RQS_OFS) begin
            rqs_r <= i_pwdata[`EQO_STAT_W-1:0];
        end
    end

    // one-shot never stays selected; codes above six are ignored
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_r <= EQO_EV_INPUT;
            pol_r <= `EQO_POL_RST;
        end else if (dflt_wr) begin
            sel_r <= EQO_EV_INPUT;
            pol_r <= `EQO_POL_RST;
        end else if (ext_wr) begin
            pol_r <= i_pwdata[`EQO_EXT_POL_BIT];
            if (wsel == EQO_EV_ONCE) begin
                sel_r <= EQO_EV_OFF;
            end else if (i_pwdata[2:0] <= 3'h6) begin
                sel_r <= wsel;
            end
        end
    end

    always_comb begin
        case (sel_r)
            EQO_EV_INPUT: fire = i_input_done;
            EQO_EV_BURST: fire = i_burst_done;
            EQO_EV_SRQ: fire = srq_ev;
            EQO_EV_READING: fire = i_reading_done;
            default: fire = 1'b0;
        endcase
        if (ext_wr && wsel == EQO_EV_ONCE) begin
            fire = 1'b1;
        end
    end

    // a fresh event restarts the width instead of being dropped
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse_cnt <= 5'h0;
        end else if (fire) begin
            pulse_cnt <= PULSE_CYC;
        end else if (pulse_cnt != 5'h0) begin
            pulse_cnt <= pulse_cnt - 5'h1;
        end
    end
    assign pulse_act = pulse_cnt != 5'h0;

    // idle level is the inactive one, so the leading edge marks the event
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_r <= 1'b1;
        end else if (sel_r == EQO_EV_APERTURE_LEVEL_EVENT) begin
            ext_r <= pol_r ? i_aperture : !i_aperture;
        end else begin
            ext_r <= pol_r ? pulse_act : !pulse_act;
        end
    end

    assign mapped = i_paddr[1:0] == 2'h0 && i_paddr <= `EQO_DEFAULTS_OFS;

    // data is captured in setup, so every access has exactly one cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_r <= 32'h0;
        end else if (setup && !i_pwrite) begin
            if (i_paddr == `EQO_ERR_SUM_OFS) begin
                prdata_r <= {17'h0, main_r};
            end else if (i_paddr == `EQO_ERR_MSG_OFS) begin
                prdata_r <= {`EQO_MSG_MAX_LEN, 8'h0, msg_num};
            end else if (i_paddr == `EQO_AUX_ERR_OFS) begin
                prdata_r <= {16'h0, aux_r};
            end else if (i_paddr == `EQO_ERROR_ENABLE_MASK_OFS) begin
                prdata_r <= {17'h0, error_enable_mask_r};
            end else if (i_paddr == `EQO_STATUS_OFS) begin
                prdata_r <= {25'h0, srq_r, err_bit_r, 5'h0};
            end else if (i_paddr == `EQO_RQS_OFS) begin
                prdata_r <= {24'h0, rqs_r};
            end else if (i_paddr == `EQO_EXTERNAL_EVENT_OUTPUT_OFS) begin
                prdata_r <= {23'h0, pol_r, 5'h0, sel_r};
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end

    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_prdata = prdata_r;
    assign o_ext_out = ext_r;
    assign o_err_ind = ind_r;
    assign o_srq = srq_r;

    a_sum_zero: assert property (
        setup && !i_pwrite && i_paddr == `EQO_ERR_SUM_OFS && main_r == '0 |=> o_prdata == 32'h0)
        else $error("sum query not zero when empty");
    a_sum_clears: assert property (
        sum_rd && i_main_err_set == '0 && i_aux_err_set == '0 |=> main_r == '0 && aux_r == '0)
        else $error("sum query did not clear errors");
    a_sum_status: assert property (
        sum_rd && !err_ev |=> !err_bit_r)
        else $error("sum query left status error bit");
    a_aux_mirror: assert property (
        aux_r != '0 |-> main_r[0])
        else $error("main bit zero not set for auxiliary errors");
    a_aux_first: assert property (
        setup && !i_pwrite && i_paddr == `EQO_ERR_MSG_OFS && aux_r != '0
        |=> o_prdata[15:0] >= 16'h00C8 && o_prdata[15:0] < 16'h00D8)
        else $error("auxiliary bits not reported first");
    a_once_off: assert property (
        ext_wr && wsel == EQO_EV_ONCE && !dflt_wr |=> sel_r == EQO_EV_OFF ##1 pulse_act)
        else $error("one-shot did not pulse and disable");
    a_srq_sticky: assert property (
        srq_r && !stat_wr |=> srq_r)
        else $error("service request dropped without clear");
    a_defaults: assert property (
        dflt_wr |=> sel_r == EQO_EV_INPUT && !pol_r)
        else $error("defaults not restored");
    a_pulse_len: assert property (
        fire ##1 !fire [*8] |-> pulse_act && pulse_cnt == PULSE_CYC - 5'h07)
        else $error("pulse shorter than expected");
    a_idle_level: assert property (
        !pulse_act && sel_r != EQO_EV_APERTURE_LEVEL_EVENT |=> o_ext_out == !$past(pol_r))
        else $error("idle output level wrong for polarity");
    // consumption checks use x & (x - 1), independent of the index search
    a_msg_empty: assert property (
        setup && !i_pwrite && i_paddr == `EQO_ERR_MSG_OFS && aux_r == '0 && main_r[`EQO_MAIN_W-1:1] == '0
        |=> o_prdata[15:0] == 16'h0000)
        else $error("empty message query not zero");
    a_msg_len: assert property (
        setup && !i_pwrite && i_paddr == `EQO_ERR_MSG_OFS |=> o_prdata[31:24] == `EQO_MSG_MAX_LEN)
        else $error("message length limit wrong");
    a_msg_main: assert property (
        setup && !i_pwrite && i_paddr == `EQO_ERR_MSG_OFS && aux_r == '0 && main_r[`EQO_MAIN_W-1:1] != '0
        |=> o_prdata[15:0] >= 16'h0065 && o_prdata[15:0] <= 16'h0072)
        else $error("main error number outside its series");
    a_aux_consume: assert property (
        msg_rd && aux_r != '0 && i_aux_err_set == '0 |=> aux_r == ($past(aux_r) & ($past(aux_r) - 16'h0001)))
        else $error("message query did not clear lowest auxiliary bit");
    a_main_consume: assert property (
        msg_rd && aux_r == '0 && main_r[`EQO_MAIN_W-1:1] != '0 && i_main_err_set == '0 && i_aux_err_set == '0
        |=> main_r == ($past(main_r) & ($past(main_r) - 15'h0001)))
        else $error("message query did not clear lowest main bit");
    a_main_hold: assert property (
        msg_rd && aux_r != '0 && i_main_err_set == '0
        |=> ((main_r ^ $past(main_r)) & 15'h7FFE) == 15'h0000)
        else $error("main bits consumed while auxiliary pending");
    a_pend_clear: assert property (
        msg_rd && aux_r != '0 && (aux_r & (aux_r - 16'h0001)) == '0 && i_aux_err_set == '0
        |=> !main_r[0])
        else $error("pending bit not cleared after last auxiliary bit");
    a_drain_status: assert property (
        msg_rd && !err_ev |=> main_r != '0 || aux_r != '0 || !err_bit_r)
        else $error("status error bit left after registers emptied");
    a_status_err: assert property (
        err_ev |=> err_bit_r)
        else $error("enabled error did not set status bit");
    a_err_latch: assert property (
        i_main_err_set != '0
        |=> (main_r & $past(i_main_err_set) & 15'h7FFE) == ($past(i_main_err_set) & 15'h7FFE))
        else $error("error bit not latched");
    a_ind_off: assert property (
        sum_rd && i_main_err_set == '0 && i_aux_err_set == '0 |=> !o_err_ind)
        else $error("error indicator left on after sum query");
    a_code_seven: assert property (
        ext_wr && i_pwdata[2:0] == 3'h7 |=> sel_r == $past(sel_r))
        else $error("undefined event code changed the selection");
    a_aperture_level_event_pass: assert property (
        sel_r == EQO_EV_APERTURE_LEVEL_EVENT |=> o_ext_out == ($past(pol_r) ? $past(i_aperture) : !$past(i_aperture)))
        else $error("aperture level not passed to output");
    a_input_pulse: assert property (
        sel_r == EQO_EV_INPUT && i_input_done |=> pulse_cnt == PULSE_CYC)
        else $error("input complete did not start a pulse");
    a_burst_pulse: assert property (
        sel_r == EQO_EV_BURST && i_burst_done |=> pulse_cnt == PULSE_CYC)
        else $error("burst complete did not start a pulse");
    a_reading_pulse: assert property (
        sel_r == EQO_EV_READING && i_reading_done |=> pulse_cnt == PULSE_CYC)
        else $error("reading complete did not start a pulse");
    a_srq_pulse: assert property (
        srq_ev && sel_r == EQO_EV_SRQ |=> pulse_cnt == PULSE_CYC)
        else $error("enabled status event did not start a pulse");
    a_srq_set: assert property (
        srq_ev |=> o_srq)
        else $error("enabled status event did not set service request");
    a_cfg_query: assert property (
        setup && !i_pwrite && i_paddr == `EQO_EXTERNAL_EVENT_OUTPUT_OFS
        |=> o_prdata[2:0] == $past(sel_r) && o_prdata[`EQO_EXT_POL_BIT] == $past(pol_r))
        else $error("output configuration readback wrong");
endmodule

/* verification/eqo_conv_model.sv */
`timescale 1ns/1ps
module eqo_conv_model #(
    parameter int APERTURE_LEVEL_EVENT_CYC = 8
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_go, // start one reading
    input wire logic i_last, // reading ends a burst
    output logic o_aperture, // measuring window
    output logic o_input_done, // integration finished
    output logic o_reading_done, // reading finished
    output logic o_burst_done // burst finished
);
    int cnt_r;
    logic last_r;
    // a new reading is only taken when idle, as a real converter would
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 0;
            last_r <= 1'b0;
        end else if (i_go && cnt_r == 0) begin
            cnt_r <= APERTURE_LEVEL_EVENT_CYC + 2;
            last_r <= i_last;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    assign o_aperture = cnt_r > 2;
    assign o_input_done = cnt_r == 2;
    assign o_reading_done = cnt_r == 1;
    assign o_burst_done = cnt_r == 1 && last_r;
endmodule

/* verification/eqo_error_event_tb_top.sv */
`timescale 1ns/1ps
`include "eqo_regs.svh"
module eqo_error_event_tb_top;
    import eqo_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, last = 0, pol_q = 0, err;
    logic [7:0] paddr = 8'h00, sevt = 8'h00;
    logic [31:0] pwdata = 32'h0, q, prdata;
    logic [14:0] merr = 15'h0;
    logic [15:0] aerr = 16'h0;
    logic pready, pslverr, ext_out, err_ind, srq, aperture_level_event, in_done, rd_done, b_done;
    int failures = 0, total_checks = 0, act_cnt = 0;
    int msgs[5] = '{202, 205, 103, 107, 0};
    eqo_evt_t codes[3] = '{EQO_EV_INPUT, EQO_EV_BURST, EQO_EV_READING};

    eqo_error_event DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_main_err_set(merr), .i_aux_err_set(aerr), .i_status_evt(sevt),
        .i_input_done(in_done), .i_burst_done(b_done), .i_reading_done(rd_done), .i_aperture(aperture_level_event),
        .o_ext_out(ext_out), .o_err_ind(err_ind), .o_srq(srq));
    eqo_conv_model #(.APERTURE_LEVEL_EVENT_CYC(8)) conv (.i_core_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_last(last),
        .o_aperture(aperture_level_event), .o_input_done(in_done), .o_reading_done(rd_done), .o_burst_done(b_done));

    always #25 clk = ~clk;
    // counts edges at which the output sits at its active level
    always @(posedge clk) if (ext_out === pol_q) act_cnt++;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask
    task automatic pulse(input logic [7:0] s, input logic [14:0] m, input logic [15:0] a, input logic g, int w);
        sevt <= s;
        merr <= m;
        aerr <= a;
        go <= g;
        last <= g;
        @(posedge clk);
        sevt <= 8'h00;
        merr <= 15'h0;
        aerr <= 16'h0;
        go <= 1'b0;
        repeat (w) @(posedge clk);
    endtask
    task automatic cfg(input logic [2:0] ev, input logic p);
        apb(1'b1, `EQO_EXTERNAL_EVENT_OUTPUT_OFS, {23'h0, p, 5'h0, ev});
        repeat (3) @(posedge clk);
        pol_q = p;
        act_cnt = 0;
        chk("idle level", !p, ext_out);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd("external_event_output rst", `EQO_EXTERNAL_EVENT_OUTPUT_OFS, 32'h107, 32'h001);
        rd("sum empty", `EQO_ERR_SUM_OFS, 32'hFFFFFFFF, 32'h0);
        rd("msg empty", `EQO_ERR_MSG_OFS, 32'hFF00FFFF, 32'hFF000000);
        rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        chk("slverr", 1, err);
        pulse(8'h00, 15'h0088, 16'h0024, 1'b0, 3);
        chk("err ind on", 1, err_ind);
        rd("aux latched", `EQO_AUX_ERR_OFS, 32'hFFFFFFFF, 32'h24);
        rd("stat err", `EQO_STATUS_OFS, 32'h20, 32'h20);
        foreach (msgs[i]) rd("msg seq", `EQO_ERR_MSG_OFS, 32'hFF00FFFF, 32'hFF000000 | msgs[i]);
        rd("stat drained", `EQO_STATUS_OFS, 32'h20, 32'h0);
        apb(1'b1, `EQO_ERROR_ENABLE_MASK_OFS, 32'h0);
        pulse(8'h00, 15'h0010, 16'h0, 1'b0, 3);
        rd("masked stat", `EQO_STATUS_OFS, 32'h20, 32'h0);
        apb(1'b1, `EQO_ERROR_ENABLE_MASK_OFS, 32'h7FFF);
        pulse(8'h00, 15'h0240, 16'h0002, 1'b0, 3);
        rd("stat set", `EQO_STATUS_OFS, 32'h20, 32'h20);
        rd("sum", `EQO_ERR_SUM_OFS, 32'hFFFFFFFF, 32'h251);
        rd("sum stat", `EQO_STATUS_OFS, 32'h20, 32'h0);
        chk("err ind off", 0, err_ind);
        rd("sum cleared", `EQO_ERR_SUM_OFS, 32'hFFFFFFFF, 32'h0);
        foreach (codes[i]) begin
            cfg(codes[i], i[0]);
            pulse(8'h00, 15'h0, 16'h0, 1'b1, 40);
            chk("event pulse", 20, act_cnt);
        end
        cfg(EQO_EV_OFF, 1'b0);
        pulse(8'h3F, 15'h0, 16'h0, 1'b1, 40);
        chk("off pulse", 0, act_cnt);
        for (int p = 0; p < 2; p++) begin
            cfg(EQO_EV_APERTURE_LEVEL_EVENT, p[0]);
            pulse(8'h00, 15'h0, 16'h0, 1'b1, 40);
            chk("aperture", 8, act_cnt);
        end
        apb(1'b1, `EQO_RQS_OFS, 32'h01);
        rd("rqs", `EQO_RQS_OFS, 32'hFF, 32'h01);
        cfg(EQO_EV_SRQ, 1'b1);
        pulse(8'h01, 15'h0, 16'h0, 1'b0, 30);
        pulse(8'h01, 15'h0, 16'h0, 1'b0, 30);
        pulse(8'h02, 15'h0, 16'h0, 1'b0, 30);
        chk("status pulses", 40, act_cnt);
        chk("srq pin", 1, srq);
        rd("srq sticky", `EQO_STATUS_OFS, 32'h40, 32'h40);
        act_cnt = 0;
        // second event lands six edges after the first and stretches the pulse
        pulse(8'h01, 15'h0, 16'h0, 1'b0, 5);
        pulse(8'h01, 15'h0, 16'h0, 1'b0, 30);
        chk("restart", 26, act_cnt);
        apb(1'b1, `EQO_STATUS_OFS, 32'h40);
        chk("srq clear", 0, srq);
        cfg(EQO_EV_OFF, 1'b1);
        apb(1'b1, `EQO_EXTERNAL_EVENT_OUTPUT_OFS, 32'h102);
        repeat (30) @(posedge clk);
        chk("once pulse", 20, act_cnt);
        rd("once off", `EQO_EXTERNAL_EVENT_OUTPUT_OFS, 32'h107, 32'h100);
        apb(1'b1, `EQO_EXTERNAL_EVENT_OUTPUT_OFS, 32'h007);
        rd("code 7", `EQO_EXTERNAL_EVENT_OUTPUT_OFS, 32'h107, 32'h000);
        apb(1'b1, `EQO_ERROR_ENABLE_MASK_OFS, 32'h0);
        apb(1'b1, `EQO_DEFAULTS_OFS, 32'h1);
        rd("dflt event", `EQO_EXTERNAL_EVENT_OUTPUT_OFS, 32'h107, 32'h001);
        rd("dflt mask", `EQO_ERROR_ENABLE_MASK_OFS, 32'h7FFF, 32'h7FFF);
        conclude();
    end
endmodule
